// [dpot_host.sv]
// host serial master model, mode 0, sck 8 system clocks
// assumes the bench calls frame from its main sequence
`timescale 1ns/100ps
module dpot_host (
  // system
  input wire logic clk,
  // serial
  output logic     csN,
  output logic     sck,
  output logic     sdi,
  input wire logic sdo
);
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  task automatic frame(input logic [31:0] tx, input int n, output logic [15:0] rx);
    rx = '0;
    @(posedge clk) csN <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) sdi <= tx[31-i];
      repeat (3) @(posedge clk);
      sck <= 1'b1;
      repeat (2) @(posedge clk);
      #1 rx = {rx[14:0], sdo};
      repeat (2) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    csN <= 1'b1;
    // released line toggles so no stale bit is mistaken for data
    sdi <= ~sdi;
    repeat (16) @(posedge clk);
  endtask : frame
endmodule : dpot_host

// [dpot_pkg.sv]
// package for the digital potentiometer serial command block
// assumes one 25 MHz system clock; serial pins are sampled, not used as clocks
// Contract
// - frame opens on select fall with type code, zero, two select bits, direction
// - wiper read: 1000_0000, device returns six don't-cares, then ten wiper bits
// - wiper write: 1010_0000, host sends ten bits, loaded into wiper register
// - stored read: 1010 sel 00, device returns selected stored value right-justified
// - stored write: 1100 sel 00 plus ten bits; select rise starts write cycle
// - direction 1, 1100 sel 00 two-byte frame copies stored value into wiper
// - direction 0, 1110 sel 00 copies wiper into stored; select rise starts write
// - status read: 0100_0001, one don't-care byte, then seven zeros and busy flag
// - carried ten-bit value is the wiper register, bit 9 most significant
// - frame executes only when select bits match address pins
// - two register-select bits pick one of four stored registers
// - busy flag reads one during a nonvolatile write cycle, else zero
package dpot_pkg;

  localparam int         SYS_CLK_HZ      = 25_000_000;
  // nonvolatile write time in microseconds
  localparam int         WRITE_TIME_US   = 10_000;
  localparam int         WRITE_CYCLES    = WRITE_TIME_US * (SYS_CLK_HZ / 1_000_000);

  // identification byte fields; type code is arbitrary
  localparam logic [3:0] DEV_TYPE_CODE   = 4'ha;
  localparam int         ID_TYPE_POS     = 4;
  localparam int         ID_ZERO_POS     = 3;
  localparam int         ID_SEL_POS      = 1;
  localparam int         ID_DIR_POS      = 0;

  // instruction byte layout: opcode in [7:4], register select in [3:2]
  localparam int         INS_OP_POS      = 4;
  localparam int         INS_SEL_POS     = 2;
  localparam logic [7:0] INS_RD_WIPER    = 8'h80;
  localparam logic [7:0] INS_WR_WIPER    = 8'ha0;
  localparam logic [7:0] INS_STATUS      = 8'h41;
  localparam logic [3:0] OP_STORED_RD    = 4'ha;
  localparam logic [3:0] OP_STORED_WR    = 4'hc;
  localparam logic [3:0] OP_COPY_TO_STOR = 4'he;

  localparam int         POS_W           = 10;
  localparam logic [9:0] POS_RESET       = 10'h000;
  localparam int         SHORT_BITS      = 16;
  localparam int         LONG_BITS       = 32;

  typedef enum logic [3:0] {
    DPOT_CMD_NONE   = 4'h1,
    DPOT_CMD_WIPER  = 4'h2,
    DPOT_CMD_STORED = 4'h4,
    DPOT_CMD_COPY   = 4'h8
  } dpot_cmd_t;

  // serial pins after synchronisation
  typedef struct packed {
    logic csN;
    logic sck;
    logic sdi;
  } dpot_pins_t;

endpackage : dpot_pkg

// [dpot_spi_frames.sv]
// serial command framing for one wiper and four stored positions
// assumes mode 0: host changes data on falling clock, device samples on rising
`timescale 1ns/100ps
module dpot_spi_frames
  import dpot_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        nrst,
  // serial pins
  input  wire logic        csN,
  input  wire logic        sck,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdoEn,
  // device address straps
  input  wire logic        dev_select_hi,
  input  wire logic        dev_select_lo,
  // state seen by the analog array
  output logic [POS_W-1:0] wiper_position_register,
  output logic             writeBusy
);

  dpot_pins_t s1, s2, s3;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1 <= '{csN: 1'b1, sck: 1'b0, sdi: 1'b0};
      s2 <= '{csN: 1'b1, sck: 1'b0, sdi: 1'b0};
      s3 <= '{csN: 1'b1, sck: 1'b0, sdi: 1'b0};
    end else begin
      s1 <= '{csN: csN, sck: sck, sdi: sdi};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts once second and third stages agree
  logic csLvl, sckLvl;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      csLvl  <= 1'b1;
      sckLvl <= 1'b0;
    end else begin
      if (s2.csN == s3.csN) csLvl <= s3.csN;
      if (s2.sck == s3.sck) sckLvl <= s3.sck;
    end
  end
  wire csFall  = csLvl && !s3.csN && !s2.csN;
  wire csRise  = !csLvl && s3.csN && s2.csN;
  wire sckRise = !csLvl && !sckLvl && s3.sck && s2.sck;
  wire sckFall = !csLvl && sckLvl && !s3.sck && !s2.sck;

  logic [5:0]       bitCnt;
  logic [31:0]      shiftIn;
  logic [15:0]      shiftOut;
  logic [POS_W-1:0] stored_position_register [4];
  logic [31:0]      busyCnt;

  wire [5:0]  next_bitCnt  = (bitCnt == 6'h3f) ? bitCnt : bitCnt + 6'h01;
  wire [31:0] next_shiftIn = {shiftIn[30:0], s3.sdi};

  // id byte is the top of the first 16 received bits
  wire [7:0] idByte  = shiftIn[15:8];
  wire [7:0] insByte = shiftIn[7:0];
  wire [7:0] fIdByte = shiftIn[31:24];
  wire [7:0] fInsByte = shiftIn[23:16];
  wire [POS_W-1:0] rxData = shiftIn[POS_W-1:0];

  function automatic logic idOk(input logic [7:0] b, input logic hi, input logic lo);
    idOk = b[7:ID_TYPE_POS] == DEV_TYPE_CODE && !b[ID_ZERO_POS]
        && b[ID_SEL_POS+1] == hi && b[ID_SEL_POS] == lo;
  endfunction

  wire [1:0] selHdr  = insByte[INS_SEL_POS+1:INS_SEL_POS];
  wire [1:0] selFull = fInsByte[INS_SEL_POS+1:INS_SEL_POS];
  wire       hdrOk   = idOk(idByte, dev_select_hi, dev_select_lo);
  wire       fullOk  = idOk(fIdByte, dev_select_hi, dev_select_lo);
  wire       hdrRd   = idByte[ID_DIR_POS];
  wire       fullRd  = fIdByte[ID_DIR_POS];
  wire [1:0] lowHdr  = insByte[1:0];
  wire [1:0] lowFull = fInsByte[1:0];

  // opcode nibble and the two trailing zero bits of the instruction byte
  wire [3:0] opHdr    = insByte[7:INS_OP_POS];
  wire [3:0] opFull   = fInsByte[7:INS_OP_POS];
  wire       tailHdr  = lowHdr == 2'h0;
  wire       tailFull = lowFull == 2'h0;

  // header seen as a read or a write addressed to this device
  wire       hdrRead   = hdrOk && hdrRd;
  wire       hdrWrite  = hdrOk && !hdrRd;
  wire       fullWrite = fullOk && !fullRd;

  // read data chosen once the instruction byte is complete
  wire        isRdWiper  = hdrRead && insByte == INS_RD_WIPER;
  wire        isRdStored = hdrRead && opHdr == OP_STORED_RD && tailHdr;
  wire        isStatus   = hdrRead && insByte == INS_STATUS;

  // wiper register is the carried value
  wire [15:0] wiperWord  = {6'h00, wiper_position_register};
  wire [15:0] storedWord = {6'h00, stored_position_register[selHdr]};
  // don't-care byte, seven zeros, busy flag last
  wire [15:0] statusWord = {8'h00, 7'h00, writeBusy};

  // don't-care output bits go out as zero so the host sees a fixed pattern
  wire [15:0] rdWord     = isRdWiper  ? wiperWord
                         : isRdStored ? storedWord
                         : statusWord;
  wire        rdActive   = isRdWiper || isRdStored || isStatus;

  // completed frames, decided at select rise; exact bit count needed
  // a host that over-clocks a frame is refused as well, not truncated
  wire frame16 = bitCnt == 6'(SHORT_BITS);
  wire frame32 = bitCnt == 6'(LONG_BITS);

  wire doWrWiper  = frame32 && fullWrite && fInsByte == INS_WR_WIPER;
  wire doWrStored = frame32 && fullWrite && opFull == OP_STORED_WR && tailFull;
  wire doCopyIn   = frame16 && hdrRead && opHdr == OP_STORED_WR && tailHdr;
  wire doCopyOut  = frame16 && hdrWrite && opHdr == OP_COPY_TO_STOR && tailHdr;

  // at most one command per frame; anything unmatched leaves cmd at none
  dpot_cmd_t cmd;
  assign cmd = !csRise                ? DPOT_CMD_NONE
             : (doWrWiper || doCopyIn) ? DPOT_CMD_WIPER
             : doWrStored              ? DPOT_CMD_STORED
             : doCopyOut               ? DPOT_CMD_COPY
             : DPOT_CMD_NONE;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bitCnt  <= 6'h00;
      shiftIn <= 32'h0;
    end else if (csFall) begin
      bitCnt  <= 6'h00;
      shiftIn <= 32'h0;
    end else if (sckRise) begin
      bitCnt  <= next_bitCnt;
      shiftIn <= next_shiftIn;
    end
  end

  // output shifts on falling clock so the host samples on the next rise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shiftOut <= 16'h0;
      sdo      <= 1'b0;
      sdoEn    <= 1'b0;
    end else if (csLvl) begin
      sdo      <= 1'b0;
      sdoEn    <= 1'b0;
    end else if (sckFall && bitCnt == 6'(SHORT_BITS) && rdActive) begin
      sdo      <= rdWord[15];
      shiftOut <= {rdWord[14:0], 1'b0};
      sdoEn    <= 1'b1;
    end else if (sckFall && sdoEn) begin
      sdo      <= shiftOut[15];
      shiftOut <= {shiftOut[14:0], 1'b0};
      sdoEn    <= bitCnt < 6'(LONG_BITS);
    end
  end

  // no reset of the stored array: it stands for nonvolatile cells
  always_ff @(posedge clk) begin
    unique case (cmd)
      DPOT_CMD_STORED: stored_position_register[selFull] <= rxData;
      DPOT_CMD_COPY:   stored_position_register[selHdr]  <= wiper_position_register;
      DPOT_CMD_WIPER,
      DPOT_CMD_NONE:   ;
    endcase
  end

  // new wiper value: a copy from a stored cell or the received data
  wire [POS_W-1:0] next_wiper = doCopyIn ? stored_position_register[selHdr] : rxData;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wiper_position_register <= POS_RESET;
    end else if (cmd == DPOT_CMD_WIPER) begin
      wiper_position_register <= next_wiper;
    end
  end

  // busy for the write time after a stored write or copy out
  // a new write during a running cycle restarts the full write time
  wire        startWrite   = cmd == DPOT_CMD_STORED || cmd == DPOT_CMD_COPY;
  wire        busyRunning  = busyCnt != 32'h0;
  wire [31:0] next_busyCnt = busyCnt - 32'h1;
  wire        lastBusy     = busyCnt == 32'h1;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busyCnt   <= 32'h0;
      writeBusy <= 1'b0;
    end else if (startWrite) begin
      busyCnt   <= 32'(WRITE_CYCLES);
      writeBusy <= 1'b1;
    end else if (busyRunning) begin
      busyCnt   <= next_busyCnt;
      writeBusy <= !lastBusy;
    end
  end

  // limitation: the busy flag only reports timing; the stored cells
  // take their new value at once, there is no partial-write model

endmodule : dpot_spi_frames

// [dpot_spi_frames_monitor.sv]
// checker for the potentiometer serial block
// assumes only the top module's ports and one clock domain
`timescale 1ns/100ps
module dpot_spi_frames_monitor
  import dpot_pkg::*;
(
  // system
  input wire logic             clk,
  input wire logic             nrst,
  // serial
  input wire logic             csN,
  input wire logic             sdo,
  input wire logic             sdoEn,
  // state
  input wire logic [POS_W-1:0] wiper_position_register,
  input wire logic             writeBusy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_SDO_QUIET: assert property (!sdoEn |-> !sdo)
    else $error("sdo high while not driving");
  AST_EN_OFF_CS: assert property (csN [*6] |-> !sdoEn)
    else $error("sdo driven while deselected");
  AST_EN_IDLE_START: assert property ($fell(csN) |-> !sdoEn [*8])
    else $error("sdo driven during id byte");
  AST_EN_START: assert property ($rose(sdoEn) |-> !csN && !$past(csN, 8))
    else $error("sdo enabled outside a frame");
  AST_WIPER_AFTER_CS: assert property ($changed(wiper_position_register) |-> csN && $past(csN, 2))
    else $error("wiper changed inside a frame");
  AST_BUSY_START: assert property ($rose(writeBusy) |-> csN && $past(csN, 2))
    else $error("write cycle started before select rise");
  AST_BUSY_WIPER: assert property ($rose(writeBusy) |-> $stable(wiper_position_register))
    else $error("stored write moved the wiper");
  AST_BUSY_HOLD: assert property ($rose(writeBusy) |=> writeBusy [*8])
    else $error("busy flag dropped early");
endmodule : dpot_spi_frames_monitor

bind dpot_spi_frames dpot_spi_frames_monitor dpot_spi_frames_monitor_inst (.clk(clk), .nrst(nrst), .csN(csN),
  .sdo(sdo), .sdoEn(sdoEn), .wiper_position_register(wiper_position_register), .writeBusy(writeBusy));

// [dpot_spi_frames_tb_top.sv]
// self-checking bench for the potentiometer serial block
// assumes the host model drives the select, clock and data-in serial pins
`timescale 1ns/100ps
module dpot_spi_frames_tb_top;
  import dpot_pkg::*;
  logic clk = 0, nrst = 0, selHi = 0, selLo = 0;
  wire logic csN, sck, sdi, sdo, sdoEn, writeBusy;
  wire logic [POS_W-1:0] wiper;
  logic [15:0] rx;
  int num_errors = 0, checked = 0;
  initial forever #20 clk = ~clk;
  dpot_spi_frames dpot_spi_frames_inst (.clk(clk), .nrst(nrst), .csN(csN), .sck(sck), .sdi(sdi), .sdo(sdo),
    .sdoEn(sdoEn), .dev_select_hi(selHi), .dev_select_lo(selLo), .wiper_position_register(wiper),
    .writeBusy(writeBusy));
  dpot_host dpot_host_inst (.clk(clk), .csN(csN), .sck(sck), .sdi(sdi), .sdo(sdo));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic dir, input logic [1:0] a, input logic [7:0] ins, input logic [9:0] v, input int n);
    dpot_host_inst.frame({DEV_TYPE_CODE, 1'b0, a, dir, ins, 6'h00, v}, n, rx);
  endtask : xfer
  task automatic t_wiper;
    xfer(0, 2'h2, INS_WR_WIPER, 10'h2a5, 32);
    xfer(1, 2'h2, INS_RD_WIPER, 10'h000, 32);
    chk(rx, 16'h02a5);
    chk(wiper, 16'h02a5);
    chk(sdoEn, 16'h0000);
  endtask : t_wiper
  task automatic t_refuse;
    xfer(0, 2'h1, INS_WR_WIPER, 10'h155, 32);
    chk(wiper, 16'h02a5);
    xfer(0, 2'h2, INS_WR_WIPER, 10'h155, 24);
    chk(wiper, 16'h02a5);
  endtask : t_refuse
  task automatic t_stored;
    for (int s = 0; s < 4; s++) xfer(0, 2'h2, {OP_STORED_WR, 2'(s), 2'h0}, {2'(s), 8'h3c}, 32);
    chk(writeBusy, 16'h0001);
    xfer(1, 2'h2, INS_STATUS, 10'h000, 32);
    chk(rx, 16'h0001);
    for (int s = 0; s < 4; s++) begin
      xfer(1, 2'h2, {OP_STORED_RD, 2'(s), 2'h0}, 10'h000, 32);
      chk(rx, {6'h00, 2'(s), 8'h3c});
    end
  endtask : t_stored
  task automatic t_copy;
    xfer(1, 2'h2, {OP_STORED_WR, 2'h2, 2'h0}, 10'h000, 16);
    chk(wiper, 16'h023c);
    xfer(0, 2'h2, INS_WR_WIPER, 10'h0f0, 32);
    xfer(0, 2'h2, {OP_COPY_TO_STOR, 2'h1, 2'h0}, 10'h000, 16);
    xfer(1, 2'h2, {OP_STORED_RD, 2'h1, 2'h0}, 10'h000, 32);
    chk(rx, 16'h00f0);
  endtask : t_copy
  task automatic wrap_up;
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    selHi <= 1'b1;
    repeat (8) @(posedge clk);
    xfer(1, 2'h2, INS_STATUS, 10'h000, 32);
    chk(rx, 16'h0000);
    t_wiper();
    t_refuse();
    t_stored();
    t_copy();
    wrap_up();
  end
  // frames take about 4700 clocks; this allows five times that
  initial begin
    #1_000_000;
    num_errors++;
    wrap_up();
  end
endmodule : dpot_spi_frames_tb_top
